// *** core/wrsf_framer.sv ***
// Weight report string framer and serial port configuration
`timescale 1ns/100ps
`include "wrsf_params.svh"
module wrsf_framer #(
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    resetn_i,
  // Report request
  input  wire logic                    req_valid_i,
  output logic                         req_ready_o,
  input  wire wrsf_pkg::wrsf_req_s     req_i,
  input  wire logic                    rs485_mode_i,
  input  wire logic                    clock_card_i,
  // Character stream toward the serial transmitters
  output logic                         tx_valid_o,
  input  wire logic                    tx_ready_i,
  output logic       [7:0]             tx_data_o,
  output logic                         tx_to_host_o,
  // Port configuration writes
  input  wire logic                    cfg_wr_i,
  input  wire logic                    cfg_host_i,
  input  wire logic  [3:0]             cfg_baud_i,
  input  wire logic  [3:0]             cfg_frame_i,
  input  wire logic                    prn_repeater_i,
  input  wire logic                    host_on_com2_i,
  // Port configuration and bit-rate ticks
  output wrsf_pkg::wrsf_port_cfg_s     com1_cfg_o,
  output wrsf_pkg::wrsf_port_cfg_s     com2_cfg_o,
  output logic                         com1_is_host_o,
  output logic       [1:0]             bit_tick_o
);
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_PREFIX = 3'b010,
    ST_BODY   = 3'b100
  } wrsf_state_e;

  wrsf_state_e             st_reg;
  wrsf_pkg::wrsf_req_s     req_reg;
  logic                    date_en_reg;
  logic [3:0]              step_reg;
  logic [4:0]              chr_reg;
  logic [1:0]              grp_reg;
  wrsf_pkg::wrsf_field_e   fld;
  wrsf_pkg::wrsf_scale_s   cur;
  logic [4:0]              fld_len;
  logic                    skip;
  logic                    emit;
  logic                    adv;
  logic [7:0]              chr;
  logic                    fifo_in_ready;
  wrsf_pkg::wrsf_port_cfg_s host_cfg_reg;
  wrsf_pkg::wrsf_port_cfg_s prn_cfg_reg;
  logic                    rpt_prev_reg;
  wrsf_pkg::wrsf_port_cfg_s wr_frame;
  wrsf_pkg::wrsf_port_cfg_s rpt_frame;
  logic [16:0]             wr_div;

  // Field order per format; table step index to field
  function automatic wrsf_pkg::wrsf_field_e field_at(
      input wrsf_pkg::wrsf_fmt_e fmt, input logic [3:0] s);
    wrsf_pkg::wrsf_field_e f;
    f = wrsf_pkg::F_END;
    case (fmt)
      wrsf_pkg::FMT_STANDARD: begin
        case (s)
          4'h0: f = wrsf_pkg::F_COND;
          4'h1: f = wrsf_pkg::F_COMMA;
          4'h2: f = wrsf_pkg::F_TYPE;
          4'h3: f = wrsf_pkg::F_COMMA;
          4'h4: f = wrsf_pkg::F_WEIGHT;
          4'h5: f = wrsf_pkg::F_COMMA;
          4'h6: f = wrsf_pkg::F_UNIT;
          4'h7: f = wrsf_pkg::F_CR;
          4'h8: f = wrsf_pkg::F_LF;
          default: f = wrsf_pkg::F_END;
        endcase
      end
      wrsf_pkg::FMT_MULTI: begin
        case (s)
          4'h0: f = wrsf_pkg::F_COND;
          4'h1: f = wrsf_pkg::F_COMMA;
          4'h2: f = wrsf_pkg::F_WEIGHT;
          4'h3: f = wrsf_pkg::F_COMMA;
          4'h4: f = wrsf_pkg::F_UNIT;
          4'h5: f = wrsf_pkg::F_GSEP;
          4'h6: f = wrsf_pkg::F_CR;
          4'h7: f = wrsf_pkg::F_LF;
          default: f = wrsf_pkg::F_END;
        endcase
      end
      default: begin
        case (s)
          4'h0: f = wrsf_pkg::F_SCALE;
          4'h1: f = wrsf_pkg::F_COND;
          4'h2: f = wrsf_pkg::F_COMMA;
          4'h3: f = wrsf_pkg::F_WEIGHT;
          4'h4: f = wrsf_pkg::F_COMMA;
          4'h5: f = wrsf_pkg::F_PT;
          4'h6: f = wrsf_pkg::F_TARE;
          4'h7: f = wrsf_pkg::F_COMMA;
          4'h8: f = wrsf_pkg::F_ZERO;
          4'h9: f = wrsf_pkg::F_COMMA;
          4'ha: f = wrsf_pkg::F_UNIT;
          4'hb: f = wrsf_pkg::F_DSEP;
          4'hc: f = wrsf_pkg::F_DATE;
          4'hd: f = wrsf_pkg::F_CR;
          4'he: f = wrsf_pkg::F_LF;
          default: f = wrsf_pkg::F_END;
        endcase
      end
    endcase
    return f;
  endfunction

  // Condition code; over and under range come out in every format, multi-scale strings included
  function automatic logic [15:0] cond_code(input wrsf_pkg::wrsf_cond_e c);
    logic [15:0] r;
    case (c)
      wrsf_pkg::COND_STABLE:      r = `WRSF_CODE_STABLE;
      wrsf_pkg::COND_OVER_RANGE:  r = `WRSF_CODE_OVER;
      wrsf_pkg::COND_UNDER_RANGE: r = `WRSF_CODE_UNDER;
      wrsf_pkg::COND_MICROVOLT:   r = `WRSF_CODE_MICROVOLT;
      wrsf_pkg::COND_POINTS:      r = `WRSF_CODE_POINTS;
      default:                    r = `WRSF_CODE_UNSTABLE;
    endcase
    return r;
  endfunction

  // Blank fill keeps fixed columns for short numbers
  function automatic logic [7:0] pad(input logic [7:0] c);
    return (c == `WRSF_ASC_NUL) ? `WRSF_ASC_SPACE : c;
  endfunction

  // Current scale group and field decode
  always_comb begin
    fld  = field_at(req_reg.fmt, step_reg);
    cur  = req_reg.scale[(req_reg.fmt == wrsf_pkg::FMT_MULTI) ?
                         grp_reg : req_reg.active];
    case (fld)
      wrsf_pkg::F_COND, wrsf_pkg::F_TYPE,
      wrsf_pkg::F_PT, wrsf_pkg::F_UNIT: fld_len = `WRSF_LEN_CODE;
      wrsf_pkg::F_WEIGHT, wrsf_pkg::F_TARE: fld_len = `WRSF_LEN_VALUE;
      wrsf_pkg::F_DATE:                   fld_len = `WRSF_LEN_DATE;
      default:                            fld_len = `WRSF_LEN_ONE;
    endcase
    // Date parts drop out unless both conditions held at request time
    skip = ((fld == wrsf_pkg::F_DSEP || fld == wrsf_pkg::F_DATE) &&
            !date_en_reg) ||
           (fld == wrsf_pkg::F_GSEP && grp_reg == `WRSF_LAST_SCALE);
  end

  // Character at the current position; index 0 is the leftmost
  always_comb begin
    logic [4:0] hi;
    hi  = fld_len - 5'd1 - chr_reg;
    chr = `WRSF_ASC_COMMA;
    if (st_reg == ST_PREFIX) begin
      chr = req_reg.node[1 - chr_reg[0]];
    end else begin
      case (fld)
        wrsf_pkg::F_SCALE:  chr = `WRSF_ASC_ONE + {6'h00, req_reg.active};
        wrsf_pkg::F_COND:   chr = 8'(cond_code(cur.cond) >> {hi[0], 3'h0});
        wrsf_pkg::F_TYPE: begin
          case (req_reg.wtype)
            wrsf_pkg::TYPE_NET:
              chr = 8'(`WRSF_CODE_NET >> {hi[0], 3'h0});
            wrsf_pkg::TYPE_MICROVOLT:
              chr = 8'(`WRSF_CODE_MICROVOLT >> {hi[0], 3'h0});
            wrsf_pkg::TYPE_CONVERTER_POINTS:
              chr = 8'(`WRSF_CODE_POINTS >> {hi[0], 3'h0});
            default:
              chr = 8'(`WRSF_CODE_GROSS >> {hi[0], 3'h0});
          endcase
        end
        wrsf_pkg::F_WEIGHT: chr = pad(cur.weight[hi[2:0]]);
        wrsf_pkg::F_PT:     chr = 8'((req_reg.preset ? `WRSF_CODE_PRESET :
                                   `WRSF_CODE_BLANK) >> {hi[0], 3'h0});
        wrsf_pkg::F_TARE:   chr = pad(req_reg.tare[hi[2:0]]);
        wrsf_pkg::F_ZERO:   chr = `WRSF_ASC_ZERO;
        wrsf_pkg::F_UNIT:   chr = pad(cur.unit[hi[0]]);
        wrsf_pkg::F_DATE:   chr = req_reg.date[hi];
        wrsf_pkg::F_CR:     chr = `WRSF_ASC_CR;
        wrsf_pkg::F_LF:     chr = `WRSF_ASC_LF;
        default:            chr = `WRSF_ASC_COMMA;
      endcase
    end
  end

  // A character leaves only when the FIFO can take it
  assign emit = (st_reg == ST_PREFIX) ||
                (st_reg == ST_BODY && fld != wrsf_pkg::F_END && !skip);
  assign adv  = emit && fifo_in_ready;
  assign req_ready_o = (st_reg == ST_IDLE);

  // Request capture; options are frozen for the whole string
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_reg     <= '0;
      date_en_reg <= 1'b0;
    end else if (req_valid_i && req_ready_o) begin
      req_reg     <= req_i;
      date_en_reg <= (req_i.fmt == wrsf_pkg::FMT_EXT_DATE) &&
                     clock_card_i;
    end
  end

  // Sequencer state machine
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg   <= ST_IDLE;
      step_reg <= '0;
      chr_reg  <= '0;
      grp_reg  <= '0;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          step_reg <= '0;
          chr_reg  <= '0;
          grp_reg  <= '0;
          if (req_valid_i) begin
            st_reg <= rs485_mode_i ? ST_PREFIX : ST_BODY;
          end
        end
        ST_PREFIX: begin
          if (adv) begin
            if (chr_reg == `WRSF_LEN_NODE - 5'd1) begin
              chr_reg <= '0;
              st_reg  <= ST_BODY;
            end else begin
              chr_reg <= chr_reg + 5'd1;
            end
          end
        end
        ST_BODY: begin
          if (fld == wrsf_pkg::F_END) begin
            st_reg <= ST_IDLE;
          end else if (skip || (adv && chr_reg == fld_len - 5'd1)) begin
            chr_reg <= '0;
            // Group separator loops back for the next scale
            if (fld == wrsf_pkg::F_GSEP && !skip) begin
              step_reg <= '0;
              grp_reg  <= grp_reg + 2'd1;
            end else begin
              step_reg <= step_reg + 4'd1;
            end
          end else if (adv) begin
            chr_reg <= chr_reg + 5'd1;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // Output buffer; a stalled drain stalls the sequencer
  wrsf_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (emit),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({req_reg.to_host, chr}),
    .out_valid_o (tx_valid_o),
    .out_ready_i (tx_ready_i),
    .out_data_o  ({tx_to_host_o, tx_data_o})
  );

  // Baud code to clock divisor, rounded; unknown codes report zero
  function automatic logic [16:0] baud_div(input logic [3:0] c);
    int b;
    case (c)
      `WRSF_BSEL_9600:   b = `WRSF_BAUD_9600;
      `WRSF_BSEL_4800:   b = `WRSF_BAUD_4800;
      `WRSF_BSEL_2400:   b = `WRSF_BAUD_2400;
      `WRSF_BSEL_1200:   b = `WRSF_BAUD_1200;
      `WRSF_BSEL_115200: b = `WRSF_BAUD_115200;
      `WRSF_BSEL_57600:  b = `WRSF_BAUD_57600;
      `WRSF_BSEL_38400:  b = `WRSF_BAUD_38400;
      `WRSF_BSEL_19200:  b = `WRSF_BAUD_19200;
      default:           b = 0;
    endcase
    return (b == 0) ? 17'h00000 : 17'((`WRSF_CLK_HZ + b / 2) / b);
  endfunction

  // Framing code to data bits, parity, stop bits; zero bits means invalid
  function automatic wrsf_pkg::wrsf_port_cfg_s frame_of(
      input logic [3:0] c);
    wrsf_pkg::wrsf_port_cfg_s f;
    f = '0;
    case (c)
      `WRSF_FSEL_N81: f = '{17'h0, 4'h8, wrsf_pkg::PAR_NONE, 2'h1};
      `WRSF_FSEL_O81: f = '{17'h0, 4'h8, wrsf_pkg::PAR_ODD,  2'h1};
      `WRSF_FSEL_O72: f = '{17'h0, 4'h7, wrsf_pkg::PAR_ODD,  2'h2};
      `WRSF_FSEL_O71: f = '{17'h0, 4'h7, wrsf_pkg::PAR_ODD,  2'h1};
      `WRSF_FSEL_E81: f = '{17'h0, 4'h8, wrsf_pkg::PAR_EVEN, 2'h1};
      `WRSF_FSEL_E72: f = '{17'h0, 4'h7, wrsf_pkg::PAR_EVEN, 2'h2};
      `WRSF_FSEL_E71: f = '{17'h0, 4'h7, wrsf_pkg::PAR_EVEN, 2'h1};
      `WRSF_FSEL_N72: f = '{17'h0, 4'h7, wrsf_pkg::PAR_NONE, 2'h2};
      `WRSF_FSEL_N82: f = '{17'h0, 4'h8, wrsf_pkg::PAR_NONE, 2'h2};
      default:        f = '0;
    endcase
    return f;
  endfunction

  // Decoded write codes and repeater framing, read field by field below
  assign wr_div    = baud_div(cfg_baud_i);
  assign wr_frame  = frame_of(cfg_frame_i);
  assign rpt_frame = frame_of(`WRSF_RPT_FSEL);

  // Port settings; an invalid code leaves that part unchanged
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_cfg_reg <= '{17'(`WRSF_CLK_HZ / `WRSF_BAUD_9600), 4'h8,
                        wrsf_pkg::PAR_NONE, 2'h1};
      prn_cfg_reg  <= '{17'(`WRSF_CLK_HZ / `WRSF_BAUD_9600), 4'h8,
                        wrsf_pkg::PAR_NONE, 2'h1};
      rpt_prev_reg <= 1'b0;
    end else begin
      rpt_prev_reg <= prn_repeater_i;
      if (prn_repeater_i && !rpt_prev_reg) begin
        // Preset only on entry, so later writes still take effect
        prn_cfg_reg <= '{baud_div(`WRSF_RPT_BSEL), rpt_frame.data_bits,
                         rpt_frame.parity, rpt_frame.stop_bits};
      end else if (cfg_wr_i) begin
        if (cfg_host_i) begin
          if (wr_div != 17'h0) begin
            host_cfg_reg.divisor <= wr_div;
          end
          if (wr_frame.data_bits != 4'h0) begin
            host_cfg_reg.data_bits <= wr_frame.data_bits;
            host_cfg_reg.parity    <= wr_frame.parity;
            host_cfg_reg.stop_bits <= wr_frame.stop_bits;
          end
        end else begin
          if (wr_div != 17'h0) begin
            prn_cfg_reg.divisor <= wr_div;
          end
          if (wr_frame.data_bits != 4'h0) begin
            prn_cfg_reg.data_bits <= wr_frame.data_bits;
            prn_cfg_reg.parity    <= wr_frame.parity;
            prn_cfg_reg.stop_bits <= wr_frame.stop_bits;
          end
        end
      end
    end
  end

  // Exactly one port takes the host role at any time
  assign com1_is_host_o = !host_on_com2_i;
  assign com1_cfg_o = host_on_com2_i ? prn_cfg_reg : host_cfg_reg;
  assign com2_cfg_o = host_on_com2_i ? host_cfg_reg : prn_cfg_reg;

  // Bit-rate enable pulse per physical port
  generate
    for (genvar p = 0; p < 2; p++) begin : g_tick
      logic [16:0] cnt_reg;
      logic [16:0] div;
      assign div = (p == 0) ? com1_cfg_o.divisor : com2_cfg_o.divisor;
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          cnt_reg       <= '0;
          bit_tick_o[p] <= 1'b0;
        end else if (cnt_reg >= div - 17'h1) begin
          cnt_reg       <= '0;
          bit_tick_o[p] <= 1'b1;
        end else begin
          cnt_reg       <= cnt_reg + 17'h1;
          bit_tick_o[p] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule // wrsf_framer

// *** core/wrsf_params.svh ***
// Constants of the weight report string framer
`ifndef WRSF_PARAMS_SVH
`define WRSF_PARAMS_SVH
// Clock and baud rates
`define WRSF_CLK_HZ      100000000
`define WRSF_BAUD_9600   9600
`define WRSF_BAUD_4800   4800
`define WRSF_BAUD_2400   2400
`define WRSF_BAUD_1200   1200
`define WRSF_BAUD_115200 115200
`define WRSF_BAUD_57600  57600
`define WRSF_BAUD_38400  38400
`define WRSF_BAUD_19200  19200
// Baud selection codes
`define WRSF_BSEL_9600   4'h1
`define WRSF_BSEL_4800   4'h2
`define WRSF_BSEL_2400   4'h3
`define WRSF_BSEL_1200   4'h4
`define WRSF_BSEL_115200 4'h5
`define WRSF_BSEL_57600  4'h6
`define WRSF_BSEL_38400  4'h7
`define WRSF_BSEL_19200  4'h8
// Framing selection codes
`define WRSF_FSEL_N81    4'h1
`define WRSF_FSEL_O81    4'h2
`define WRSF_FSEL_O72    4'h3
`define WRSF_FSEL_O71    4'h4
`define WRSF_FSEL_E81    4'h5
`define WRSF_FSEL_E72    4'h6
`define WRSF_FSEL_E71    4'h7
`define WRSF_FSEL_N72    4'h8
`define WRSF_FSEL_N82    4'h9
// Reset and repeater presets
`define WRSF_RST_BSEL    4'h1
`define WRSF_RST_FSEL    4'h1
`define WRSF_RPT_BSEL    4'h2
`define WRSF_RPT_FSEL    4'h1
// Field widths in characters and the last scale index
`define WRSF_LEN_NODE    5'd2
`define WRSF_LEN_SCALE   5'd1
`define WRSF_LEN_CODE    5'd2
`define WRSF_LEN_VALUE   5'd8
`define WRSF_LEN_UNIT    5'd2
`define WRSF_LEN_DATE    5'd17
`define WRSF_LEN_ONE     5'd1
`define WRSF_LAST_SCALE  2'h3
// ASCII characters
`define WRSF_ASC_COMMA   8'h2c
`define WRSF_ASC_CR      8'h0d
`define WRSF_ASC_LF      8'h0a
`define WRSF_ASC_SPACE   8'h20
`define WRSF_ASC_ZERO    8'h30
`define WRSF_ASC_ONE     8'h31
`define WRSF_ASC_NUL     8'h00
// Two-character codes
`define WRSF_CODE_UNSTABLE  16'h5553
`define WRSF_CODE_STABLE    16'h5354
`define WRSF_CODE_OVER      16'h4f4c
`define WRSF_CODE_UNDER     16'h554c
`define WRSF_CODE_GROSS     16'h4753
`define WRSF_CODE_NET       16'h4e54
`define WRSF_CODE_MICROVOLT 16'h564c
`define WRSF_CODE_POINTS    16'h525a
`define WRSF_CODE_PRESET    16'h5054
`define WRSF_CODE_BLANK     16'h2020
`endif

// *** core/wrsf_pkg.sv ***
// Types shared by the weight report string framer
package wrsf_pkg;
  typedef enum logic [1:0] {
    FMT_STANDARD  = 2'h0,
    FMT_EXTENDED  = 2'h1,
    FMT_EXT_DATE  = 2'h2,
    FMT_MULTI     = 2'h3
  } wrsf_fmt_e;
  typedef enum logic [2:0] {
    COND_UNSTABLE   = 3'h0,
    COND_STABLE     = 3'h1,
    COND_OVER_RANGE = 3'h2,
    COND_UNDER_RANGE= 3'h3,
    COND_MICROVOLT  = 3'h4,
    COND_POINTS     = 3'h5
  } wrsf_cond_e;
  typedef enum logic [1:0] {
    TYPE_GROSS = 2'h0,
    TYPE_NET   = 2'h1,
    TYPE_MICROVOLT = 2'h2,
    TYPE_CONVERTER_POINTS = 2'h3
  } wrsf_type_e;
  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ODD  = 2'h1,
    PAR_EVEN = 2'h2
  } wrsf_par_e;
  // Body fields; one character each unless a length says otherwise
  typedef enum logic [3:0] {
    F_END, F_SCALE, F_COND, F_TYPE, F_WEIGHT, F_PT, F_TARE, F_ZERO,
    F_UNIT, F_COMMA, F_DSEP, F_DATE, F_GSEP, F_CR, F_LF
  } wrsf_field_e;
  // Leftmost character of a text field sits in the top byte
  typedef struct packed {
    wrsf_cond_e        cond;
    logic [7:0][7:0]   weight;
    logic [1:0][7:0]   unit;
  } wrsf_scale_s;
  typedef struct packed {
    wrsf_fmt_e         fmt;
    logic              to_host;
    logic [1:0][7:0]   node;
    logic [1:0]        active;
    wrsf_type_e        wtype;
    logic              preset;
    logic [7:0][7:0]   tare;
    logic [16:0][7:0]  date;
    wrsf_scale_s [3:0] scale;
  } wrsf_req_s;
  typedef struct packed {
    logic [16:0]       divisor;
    logic [3:0]        data_bits;
    wrsf_par_e         parity;
    logic [1:0]        stop_bits;
  } wrsf_port_cfg_s;
endpackage

// *** core/wrsf_fifo.sv ***
// FIFO of WIDTH-bit entries with a registered read stage
`timescale 1ns/100ps
module wrsf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Pop whenever the output stage is empty or being drained
  assign in_ready_o = (count_reg != DEPTH[AW:0]);
  assign push = in_valid_i && in_ready_o;
  assign pop  = (count_reg != '0) && (!out_valid_o || out_ready_i);

  // Storage has no reset; pointers, fill count and read stage carry state
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // Registered read stage
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem_reg[rd_ptr_reg];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule // wrsf_fifo

// *** verification/wrsf_framer_asserts.sv ***
// Port-level checks on the weight report string framer
`timescale 1ns/100ps
module wrsf_framer_chk (
  // Clock and reset
  input wire logic                     clk_i,
  input wire logic                     resetn_i,
  // Request and stream
  input wire logic                     req_valid_i,
  input wire logic                     req_ready_o,
  input wire logic                     tx_valid_o,
  input wire logic                     tx_ready_i,
  input wire logic [7:0]               tx_data_o,
  // Port setup
  input wire logic                     prn_repeater_i,
  input wire logic                     host_on_com2_i,
  input wire wrsf_pkg::wrsf_port_cfg_s com2_cfg_o,
  input wire logic                     com1_is_host_o,
  input wire logic [1:0]               bit_tick_o
);
  logic take;
  logic cr_seen_reg;
  assign take = tx_valid_o && tx_ready_i;
  // Last byte handed over was a carriage return
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i)
      cr_seen_reg <= 1'b0;
    else if (take)
      cr_seen_reg <= (tx_data_o == 8'h0d);
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  AST_ANSWER: assert property (req_valid_i && req_ready_o |-> ##[1:3] tx_valid_o)
    else $error("no byte after request");
  AST_HOLD: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o)) else $error("byte dropped in stall");
  AST_NO_NUL: assert property (take |-> tx_data_o != 8'h00)
    else $error("null byte sent");
  AST_LF_AFTER_CR: assert property (take && cr_seen_reg |-> tx_data_o == 8'h0a)
    else $error("no line feed after return");
  AST_CR_BEFORE_LF: assert property (take && tx_data_o == 8'h0a |-> cr_seen_reg)
    else $error("line feed without return");
  AST_TICK_COM1: assert property (bit_tick_o[0] |=> (!bit_tick_o[0])[*8])
    else $error("com1 ticks too close");
  AST_TICK_COM2: assert property (bit_tick_o[1] |=> (!bit_tick_o[1])[*8])
    else $error("com2 ticks too close");
  AST_HOST_ROLE: assert property (com1_is_host_o == !host_on_com2_i)
    else $error("host role wrong");
  AST_REPEATER: assert property ($rose(prn_repeater_i) && !host_on_com2_i |->
    ##[1:2] com2_cfg_o == {17'h05161, 4'h8, 2'h0, 2'h1})
    else $error("repeater preset missing");
  COV_LF: cover property (take && tx_data_o == 8'h0a);
  COV_STALL: cover property (tx_valid_o && !tx_ready_i);
  COV_RPT: cover property ($rose(prn_repeater_i));
endmodule // wrsf_framer_chk
bind wrsf_framer wrsf_framer_chk i_chk (.clk_i, .resetn_i, .req_valid_i,
  .req_ready_o, .tx_valid_o, .tx_ready_i, .tx_data_o, .prn_repeater_i,
  .host_on_com2_i, .com2_cfg_o, .com1_is_host_o, .bit_tick_o);

// *** verification/wrsf_sink.sv ***
// Byte sink standing in for the serial transmitters
`timescale 1ns/100ps
module wrsf_sink (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // Stream from the framer
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  output logic            ready_o,
  // Bench control
  input  wire logic       slow_i
);
  logic [1:0] cnt_reg;
  logic [7:0] got[$];
  // Slow mode takes one byte in four, so the FIFO backs up
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= 2'h0;
      ready_o <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      ready_o <= !slow_i || (cnt_reg == 2'h3);
    end
  end
  // Bytes for either port role land here alike
  always @(posedge clk_i) begin
    if (valid_i && ready_o)
      got.push_back(data_i);
  end
endmodule // wrsf_sink

// *** verification/tb_top.sv ***
// Self-checking bench for the weight report string framer
`timescale 1ns/100ps
module tb_top;
  logic clk_i, resetn_i, req_valid_i, req_ready_o, rs485_mode_i;
  logic clock_card_i, tx_valid_o, tx_ready_i, cfg_wr_i, cfg_host_i;
  logic prn_repeater_i, host_on_com2_i, com1_is_host_o, slow, to_host;
  logic [7:0] tx_data_o;
  logic [3:0] cfg_baud_i, cfg_frame_i;
  logic [1:0] bit_tick_o;
  wrsf_pkg::wrsf_req_s      req_i;
  wrsf_pkg::wrsf_port_cfg_s com1_cfg_o, com2_cfg_o;
  int fails, checked;
  string nl;
  wrsf_framer i_dut (.clk_i, .resetn_i, .req_valid_i, .req_ready_o, .req_i,
    .rs485_mode_i, .clock_card_i, .tx_valid_o, .tx_ready_i, .tx_data_o,
    .tx_to_host_o(to_host), .cfg_wr_i, .cfg_host_i, .cfg_baud_i, .cfg_frame_i,
    .prn_repeater_i, .host_on_com2_i, .com1_cfg_o, .com2_cfg_o,
    .com1_is_host_o, .bit_tick_o);
  wrsf_sink i_sink (.clk_i, .resetn_i, .valid_i(tx_valid_o),
    .data_i(tx_data_o), .ready_o(tx_ready_i), .slow_i(slow));
  task summarize;
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task cmp_val(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp=%h got=%h", n, e, g);
    end
  endtask
  task automatic cmp_str(input string e);
    string s;
    bit ok;
    ok = i_sink.got.size() == e.len();
    foreach (i_sink.got[i]) begin
      s = {s, string'(i_sink.got[i])};
      if (i < e.len() && i_sink.got[i] !== e[i])
        ok = 0;
    end
    checked++;
    if (!ok) begin
      fails++;
      $display("MISMATCH string exp=%s got=%s", e, s);
    end
    i_sink.got.delete();
  endtask
  // One request, waited for until its whole string has come out
  task automatic send(input string e);
    int n = 0;
    req_valid_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 3000);
    req_valid_i <= 1'b0;
    while (i_sink.got.size() < e.len() && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (8) @(posedge clk_i);
    if (n >= 3000) begin
      fails++;
      summarize;
    end else begin
      cmp_str(e);
    end
  endtask
  task cfg(input logic h, input logic [3:0] b, input logic [3:0] f);
    cfg_host_i <= h;
    cfg_baud_i <= b;
    cfg_frame_i <= f;
    cfg_wr_i <= 1'b1;
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // First four conditions and every weight type, node prefix on, stalls late
  task t_std;
    string cs[4], ts[4];
    cs = '{"US", "ST", "OL", "UL"};
    ts = '{"GS", "NT", "VL", "RZ"};
    rs485_mode_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      slow <= (i > 1);
      req_i.scale[0].cond <= wrsf_pkg::wrsf_cond_e'(i);
      req_i.wtype <= wrsf_pkg::wrsf_type_e'(i);
      send({"01", cs[i], ",", ts[i], ",     0.0,kg", nl});
    end
  endtask
  // Active scale digit, tare flag, date only with command and card
  task t_ext;
    rs485_mode_i <= 1'b0;
    req_i.active <= 2'h2;
    req_i.fmt <= wrsf_pkg::FMT_EXT_DATE;
    clock_card_i <= 1'b1;
    send({"3ST,     0.0,PT    20.8,0,kg,01/02/19 11:12:13", nl});
    clock_card_i <= 1'b0;
    send({"3ST,     0.0,PT    20.8,0,kg", nl});
    req_i.fmt <= wrsf_pkg::FMT_EXTENDED;
    req_i.preset <= 1'b0;
    clock_card_i <= 1'b1;
    send({"3ST,     0.0,      20.8,0,kg", nl});
  endtask
  // Four groups overrun the FIFO while the sink stalls
  task t_multi;
    slow <= 1'b1;
    rs485_mode_i <= 1'b1;
    req_i.fmt <= wrsf_pkg::FMT_MULTI;
    req_i.scale[0].cond <= wrsf_pkg::COND_UNSTABLE;
    req_i.scale[2].cond <= wrsf_pkg::COND_MICROVOLT;
    req_i.scale[3].cond <= wrsf_pkg::COND_POINTS;
    req_i.scale[1].unit <= 16'h0074;
    req_i.to_host <= 1'b1;
    send({"01US,     0.0,kg,ST,     0.0, t,",
      "VL,     0.0,kg,RZ,     0.0,kg", nl});
    cmp_val("to_host", 32'h1, 32'(to_host));
  endtask
  // All baud codes and framing codes 2 to 9, then the repeater preset
  task t_cfg;
    int bd[8], db[8], pr[8], sb[8];
    bd = '{9600, 4800, 2400, 1200, 115200, 57600, 38400, 19200};
    db = '{8, 7, 7, 8, 7, 7, 7, 8};
    pr = '{1, 1, 1, 2, 2, 2, 0, 0};
    sb = '{1, 2, 1, 1, 2, 1, 2, 2};
    for (int i = 0; i < 8; i++) begin
      cfg(1'b1, 4'(i + 1), 4'(i + 2));
      cmp_val("divisor", (100000000 + bd[i] / 2) / bd[i], 32'(com1_cfg_o.divisor));
      cmp_val("framing", {db[i][3:0], pr[i][1:0], sb[i][1:0]}, 32'({com1_cfg_o.data_bits, com1_cfg_o.parity, com1_cfg_o.stop_bits}));
    end
    cfg(1'b0, 4'h5, 4'h6);
    prn_repeater_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    cmp_val("repeater", {17'h05161, 4'h8, 2'h0, 2'h1}, 32'(com2_cfg_o));
    cfg(1'b0, 4'h3, 4'h2);
    cmp_val("changed", 32'h0000a2c3, 32'(com2_cfg_o.divisor));
    host_on_com2_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    cmp_val("role", 32'h0, 32'(com1_is_host_o));
    cmp_val("swap", 32'd5208, 32'(com2_cfg_o.divisor));
  endtask
  // Free-running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Quiet inputs, reset, then the scenarios in turn
  initial begin
    {resetn_i, req_valid_i, rs485_mode_i, clock_card_i, cfg_wr_i} = 5'h0;
    {cfg_host_i, prn_repeater_i, host_on_com2_i, slow} = 4'h0;
    {cfg_baud_i, cfg_frame_i} = 8'h0;
    nl = "\015\012";
    req_i = '0;
    req_i.node = 16'h3031;
    req_i.preset = 1'b1;
    req_i.tare = 64'h0000000032302e38;
    req_i.date = "01/02/19 11:12:13";
    for (int j = 0; j < 4; j++)
      req_i.scale[j] = {wrsf_pkg::COND_STABLE, 64'h0000000000302e30, 16'h6b67};
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    t_std;
    t_ext;
    t_multi;
    t_cfg;
    summarize;
  end
endmodule // tb_top
